// ---- pkg/alarm_readout_defs.svh ----
// Constants of the alarm status and temperature readout block.
// Assumes inclusion by bare name from the package and the design files.
`ifndef ALARM_READOUT_DEFS_SVH
`define ALARM_READOUT_DEFS_SVH

// Register offsets on the serial interface (7-bit address)
`define ALARM_STATUS_ADDR 7'h05
`define TEMP_READ_ADDR 7'h06
`define ALARM_MASK_ADDR 7'h07

// Alarm status bit positions
`define BIT_ZERO_PTR 15
`define BIT_COLLIDE 13
`define BIT_ONE_AWAY 12
`define BIT_TWO_AWAY 11
`define BIT_CONV_LOST 10
`define BIT_DATA_LOST 9
`define BIT_BLANKED 8
`define BIT_PATTERN 7
`define BIT_PLL 5
`define BIT_RPARITY 4
`define BIT_FPARITY 3
`define BIT_FRPARITY 2

// Reset and fixed values
`define STATUS_RESET 16'h0000
`define MASK_RESET 16'hFFFF
`define MID_SCALE 16'h8000
`define TEMP_PAD 8'h00

// Serial frame: 8 instruction bits then 16 data bits
`define INSTR_LAST 5'h07
`define DATA_LAST 5'h0F
`define DATA_DONE 5'h10

// Clock activity watchdog: cycles without a tick edge before loss
`define ACT_TIMEOUT 7'h40

// Width of the synchronised input bundle
`define IN_SYNC_W 29

`endif

// ---- pkg/alarm_pkg.sv ----
// Types of the alarm status and temperature readout block.
// Assumes the constants header is on the include path.
`default_nettype none
`include "alarm_readout_defs.svh"
package alarm_pkg;

  typedef enum logic [2:0] {
    SIF_IDLE = 3'b001,
    SIF_INSTR = 3'b010,
    SIF_DATA = 3'b100
  } sif_state_t;

  // Pin and cross-domain inputs, in synchroniser order
  typedef struct packed {
    logic [7:0] temp_raw;
    logic sdio;
    logic sden_n;
    logic sclk;
    logic data_tick;
    logic conv_tick;
    logic [7:0] wr_ptr;
    logic collide;
    logic one_away;
    logic two_away;
    logic pattern_err;
    logic pll_unlock;
    logic rparity_err;
    logic fparity_err;
    logic frparity_err;
  } in_bus_t;

  typedef struct packed {
    logic [`IN_SYNC_W-1:0] s1;
    logic [`IN_SYNC_W-1:0] s2;
  } sync_state_t;

  typedef struct packed {
    logic prev;
    logic [6:0] cnt;
    logic lost;
  } mon_state_t;

  typedef struct packed {
    sif_state_t st;
    logic [4:0] cnt;
    logic rd;
    logic [6:0] addr;
    logic [15:0] shreg;
    logic sdo;
    logic oe;
    logic sclk_prev;
    logic [15:0] status;
    logic [15:0] mask;
    logic [7:0] temp;
    logic [7:0] temp_prev;
    logic [15:0] sample;
    logic alarm;
  } top_state_t;

endpackage
`default_nettype wire

// ---- hdl/in_sync.sv ----
// Two-stage synchroniser for the whole input bundle.
// Assumes every bit is a level held for at least two clk cycles.
`default_nettype none
`include "alarm_readout_defs.svh"
module in_sync import alarm_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Bundle
  input wire logic [`IN_SYNC_W-1:0] din,
  output logic [`IN_SYNC_W-1:0] dout
);
  sync_state_t q, d;

  always_comb begin
    d.s1 = din;
    d.s2 = q.s1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign dout = q.s2;
endmodule // in_sync
`default_nettype wire

// ---- hdl/clk_activity_mon.sv ----
// Watchdog that flags a clock as lost when its tick stops toggling.
// Assumes the tick is already synchronised to clk.
`default_nettype none
`include "alarm_readout_defs.svh"
module clk_activity_mon import alarm_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Tick in, loss out
  input wire logic tick,
  output logic lost
);
  mon_state_t q, d;

  always_comb begin
    d = q;
    d.prev = tick;
    if (tick != q.prev) begin
      d.cnt = 7'h00;
      d.lost = 1'b0;
    end else if (q.cnt != `ACT_TIMEOUT) begin
      d.cnt = q.cnt + 7'h01;
    end else begin
      d.lost = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign lost = q.lost;

  a_lost_after_idle: assert property (@(posedge clk) disable iff (!rst_n) (q.cnt == `ACT_TIMEOUT && tick == q.prev) |=> lost) else $error("clock loss not flagged");
endmodule // clk_activity_mon
`default_nettype wire

// ---- hdl/alarm_status_and_temp_readout.sv ----
// Alarm status flags, alarm mask and die temperature behind a serial register port.
// Assumes alarm sources and pins are levels from other domains, held two clk cycles or more.
//
// Contract
// - Zero write pointer sets flag bit 15.
// - Zero pointer keeps flag set; host resynchronises.
// - Proximity field encodes two-away, one-away, collision.
// - Collision flag holds until resync and clear.
// - Stopped conversion clock sets bit 10.
// - Conversion-clock flag holds until restart and clear.
// - Stopped input clock sets bit 9, held.
// - Any clock-lost or collision flag sets bit 8.
// - Bit 8 high forces output to mid-scale.
// - With blanking enabled, host clears to resume.
// - Pattern mismatch sets bit 7.
// - PLL lock loss sets bit 5.
// - Rising-edge parity error sets bit 4.
// - Falling-edge parity error sets bit 3.
// - Frame parity error sets bit 2.
// - Temperature signed in bits 15:8, read-only.
// - Host write clears alarm status.
// - Mask bit one suppresses alarm; resets all ones.
`default_nettype none
`include "alarm_readout_defs.svh"
module alarm_status_and_temp_readout import alarm_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Serial register port (3-wire)
  input wire logic sclk,
  input wire logic sden_n,
  input wire logic sdio_in,
  output logic sdio_out,
  output logic sdio_oe,
  // Alarm sources
  input wire logic [7:0] wr_ptr,
  input wire logic ptr_two_away,
  input wire logic ptr_one_away,
  input wire logic ptr_collide,
  input wire logic conv_clk_tick,
  input wire logic input_data_clock_tick,
  input wire logic pattern_mismatch,
  input wire logic pll_unlock,
  input wire logic parity_rise_err,
  input wire logic parity_fall_err,
  input wire logic parity_frame_err,
  // Blanking enables
  input wire logic blank_conv_en,
  input wire logic blank_data_en,
  input wire logic blank_collide_en,
  // Temperature sensor
  input wire logic [7:0] temp_raw,
  // Converter data path
  input wire logic [15:0] sample_in,
  output logic [15:0] sample_out,
  // Masked alarm summary
  output logic alarm_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisation and clock watchdogs

  in_bus_t raw, syn;
  logic [`IN_SYNC_W-1:0] syn_vec;
  logic conv_lost;
  logic data_lost;

  always_comb begin
    raw.temp_raw = temp_raw;
    raw.sdio = sdio_in;
    raw.sden_n = sden_n;
    raw.sclk = sclk;
    raw.data_tick = input_data_clock_tick;
    raw.conv_tick = conv_clk_tick;
    raw.wr_ptr = wr_ptr;
    raw.collide = ptr_collide;
    raw.one_away = ptr_one_away;
    raw.two_away = ptr_two_away;
    raw.pattern_err = pattern_mismatch;
    raw.pll_unlock = pll_unlock;
    raw.rparity_err = parity_rise_err;
    raw.fparity_err = parity_fall_err;
    raw.frparity_err = parity_frame_err;
  end

  in_sync u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .din(raw),
    .dout(syn_vec)
  );

  assign syn = in_bus_t'(syn_vec);

  clk_activity_mon u_conv_mon (
    .clk(clk),
    .rst_n(rst_n),
    .tick(syn.conv_tick),
    .lost(conv_lost)
  );

  clk_activity_mon u_data_mon (
    .clk(clk),
    .rst_n(rst_n),
    .tick(syn.data_tick),
    .lost(data_lost)
  );

  ////////////////////////////////////////////////////////////////////////////
  // State

  top_state_t q, d;
  logic [15:0] sets;
  logic [15:0] clr_mask;
  logic clr_ev;
  logic wr_ev;
  logic [15:0] wdata;
  logic rise, fall;
  logic src_any;

  function automatic logic [15:0] read_word(input logic [6:0] a, input top_state_t s);
    case (a)
      `ALARM_STATUS_ADDR: read_word = s.status;
      `TEMP_READ_ADDR: read_word = {s.temp, `TEMP_PAD};
      `ALARM_MASK_ADDR: read_word = s.mask;
      default: read_word = 16'h0000;
    endcase
  endfunction

  always_comb begin
    d = q;
    wr_ev = 1'b0;
    wdata = 16'h0000;
    rise = syn.sclk & ~q.sclk_prev;
    fall = ~syn.sclk & q.sclk_prev;
    d.sclk_prev = syn.sclk;

    // Serial frame engine: sample on sclk rise, drive on sclk fall
    if (syn.sden_n) begin
      d.st = SIF_IDLE;
      d.cnt = 5'h00;
      d.oe = 1'b0;
    end else begin
      case (q.st)
        SIF_IDLE: begin
          d.st = SIF_INSTR;
          d.cnt = 5'h00;
        end
        SIF_INSTR: begin
          if (rise) begin
            d.shreg = {q.shreg[14:0], syn.sdio};
            d.cnt = q.cnt + 5'h01;
            if (q.cnt == `INSTR_LAST) begin
              d.rd = q.shreg[6];
              d.addr = {q.shreg[5:0], syn.sdio};
              d.st = SIF_DATA;
              d.cnt = 5'h00;
              d.shreg = q.shreg[6] ? read_word({q.shreg[5:0], syn.sdio}, q) : 16'h0000;
            end
          end
        end
        SIF_DATA: begin
          if (q.rd) begin
            if (fall && q.cnt != `DATA_DONE) begin
              d.sdo = q.shreg[15];
              d.oe = 1'b1;
              d.shreg = {q.shreg[14:0], 1'b0};
              d.cnt = q.cnt + 5'h01;
            end else if (fall) begin
              d.oe = 1'b0;
            end
          end else if (rise && q.cnt != `DATA_DONE) begin
            d.shreg = {q.shreg[14:0], syn.sdio};
            d.cnt = q.cnt + 5'h01;
            if (q.cnt == `DATA_LAST) begin
              wr_ev = 1'b1;
              wdata = {q.shreg[14:0], syn.sdio};
            end
          end
        end
        default: begin
          d.st = SIF_IDLE;
          d.oe = 1'b0;
        end
      endcase
    end

    // Alarm events from the synchronised sources
    sets = 16'h0000;
    sets[`BIT_ZERO_PTR] = (syn.wr_ptr == 8'h00);
    sets[`BIT_COLLIDE] = syn.collide;
    sets[`BIT_ONE_AWAY] = syn.one_away;
    sets[`BIT_TWO_AWAY] = syn.two_away;
    sets[`BIT_CONV_LOST] = conv_lost;
    sets[`BIT_DATA_LOST] = data_lost;
    sets[`BIT_PATTERN] = syn.pattern_err;
    sets[`BIT_PLL] = syn.pll_unlock;
    sets[`BIT_RPARITY] = syn.rparity_err;
    sets[`BIT_FPARITY] = syn.fparity_err;
    sets[`BIT_FRPARITY] = syn.frparity_err;
    // Write clears every bit written as zero; a same-cycle event wins
    clr_ev = wr_ev && (q.addr == `ALARM_STATUS_ADDR);
    clr_mask = clr_ev ? ~wdata : 16'h0000;
    // Held sources count only if this write leaves them set, so a clear can drop bit 8
    src_any = (q.status[`BIT_CONV_LOST] & ~clr_mask[`BIT_CONV_LOST]) |
              (q.status[`BIT_DATA_LOST] & ~clr_mask[`BIT_DATA_LOST]) |
              (q.status[`BIT_COLLIDE] & ~clr_mask[`BIT_COLLIDE]) |
              sets[`BIT_CONV_LOST] | sets[`BIT_DATA_LOST] | sets[`BIT_COLLIDE];
    sets[`BIT_BLANKED] = src_any;
    d.status = (q.status & ~clr_mask) | sets;
    // Without any blanking enable the blanked flag follows its sources
    if (!src_any && !(blank_conv_en | blank_data_en | blank_collide_en)) begin
      d.status[`BIT_BLANKED] = 1'b0;
    end

    if (wr_ev && q.addr == `ALARM_MASK_ADDR) begin
      d.mask = wdata;
    end

    // Temperature taken once two samples agree
    d.temp_prev = syn.temp_raw;
    if (syn.temp_raw == q.temp_prev) begin
      d.temp = q.temp_prev;
    end

    d.sample = q.status[`BIT_BLANKED] ? `MID_SCALE : sample_in;
    d.alarm = |(q.status & ~q.mask);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.st <= SIF_IDLE;
      q.status <= `STATUS_RESET;
      q.mask <= `MASK_RESET;
    end else begin
      q <= d;
    end
  end

  assign sdio_out = q.sdo;
  assign sdio_oe = q.oe;
  assign sample_out = q.sample;
  assign alarm_out = q.alarm;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_src_fault;
    (q.status[`BIT_CONV_LOST] || q.status[`BIT_DATA_LOST] || q.status[`BIT_COLLIDE]) && !clr_ev;
  endsequence

  sequence s_blanked_out;
    q.status[`BIT_BLANKED] ##1 (sample_out == `MID_SCALE);
  endsequence

  property p_blank_chain;
    s_src_fault |=> s_blanked_out;
  endproperty

  a_zero_ptr_flag: assert property (syn.wr_ptr == 8'h00 |=> q.status[`BIT_ZERO_PTR]) else $error("zero pointer not flagged");

  a_prox_field: assert property ((syn.collide || syn.one_away || syn.two_away) |=> |q.status[13:11]) else $error("proximity not flagged");

  a_collide_hold: assert property (q.status[`BIT_COLLIDE] && !clr_mask[`BIT_COLLIDE] |=> q.status[`BIT_COLLIDE]) else $error("collision flag dropped");

  a_conv_lost_flag: assert property (conv_lost |=> q.status[`BIT_CONV_LOST]) else $error("conversion clock loss not flagged");

  a_data_lost_flag: assert property (data_lost |=> q.status[`BIT_DATA_LOST]) else $error("input clock loss not flagged");

  a_blank_chain: assert property (p_blank_chain) else $error("fault did not blank the output");

  a_mid_scale: assert property (q.status[`BIT_BLANKED] |=> sample_out == `MID_SCALE) else $error("output not mid-scale");

  a_pattern_flag: assert property (syn.pattern_err |=> q.status[`BIT_PATTERN]) else $error("pattern mismatch lost");

  a_parity_flags: assert property ((syn.rparity_err || syn.fparity_err || syn.frparity_err) |=> |q.status[4:2]) else $error("parity error lost");

  a_pll_flag: assert property (syn.pll_unlock |=> q.status[`BIT_PLL]) else $error("pll unlock lost");

  a_write_clear: assert property (clr_ev && sets == 16'h0000 && wdata == 16'h0000 |=> q.status == 16'h0000) else $error("status not cleared");

  a_mask_all: assert property (q.mask == `MASK_RESET |=> !alarm_out) else $error("masked alarm reached output");

  a_flag_latched: assert property (q.status[`BIT_PATTERN] && !clr_mask[`BIT_PATTERN] |=> q.status[`BIT_PATTERN]) else $error("latched flag dropped");

endmodule // alarm_status_and_temp_readout
`default_nettype wire

// ---- verif/serial_host_model.sv ----
// Host model driving the 3-wire serial register port.
// Assumes the block's clk; sclk idles low between frames.
`default_nettype none
module serial_host_model import alarm_pkg::*; (
  // Clock
  input wire logic clk,
  // Serial pins
  output logic sclk,
  output logic sden_n,
  output logic sdio_in,
  input wire logic sdio_out,
  input wire logic sdio_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////
  logic host_oe = 1'b0;
  logic host_bit = 1'b0;
  logic last_q = 1'b0;
  // Released line shows a value that changes every cycle
  assign sdio_in = sdio_oe ? sdio_out : (host_oe ? host_bit : ~last_q);
  always @(posedge clk) last_q <= sdio_in;
  initial begin
    sclk = 1'b0;
    sden_n = 1'b1;
  end
  // Half period in clk cycles; slow for temperature
  task automatic xfer(input logic rd, input logic [6:0] addr, input logic [15:0] wd,
                      input int half, output logic [15:0] rdat);
    logic [23:0] fr;
    fr = {rd, addr, wd};
    rdat = 16'h0000;
    sden_n = 1'b0;
    host_oe = 1'b1;
    repeat (5) @(negedge clk);
    for (int i = 23; i >= 0; i--) begin
      host_oe = !(rd && i < 16);
      host_bit = fr[i];
      repeat (half) @(negedge clk);
      if (i < 16) rdat[i] = sdio_in;
      sclk = 1'b1;
      repeat (half) @(negedge clk);
      sclk = 1'b0;
    end
    repeat (half) @(negedge clk);
    host_oe = 1'b0;
    sden_n = 1'b1;
    repeat (5) @(negedge clk);
  endtask
endmodule // serial_host_model
`default_nettype wire

// ---- verif/alarm_status_and_temp_readout_tb_top.sv ----
// Self-checking testbench of the alarm status and temperature readout block.
// Assumes the host model and the design package are compiled first.
`default_nettype none
`include "alarm_readout_defs.svh"
module alarm_status_and_temp_readout_tb_top import alarm_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic sclk, sden_n, sdio_in, sdio_out, sdio_oe;
  logic [7:0] wr_ptr = 8'h01;
  logic two = 1'b0, one = 1'b0, col = 1'b0;
  logic conv_tick = 1'b0, data_tick = 1'b0;
  logic conv_run = 1'b1, data_run = 1'b1;
  logic pat = 1'b0, pll = 1'b0, rpe = 1'b0, fpe = 1'b0, frpe = 1'b0;
  logic [7:0] temp_raw = 8'h00;
  logic [15:0] sample_in = 16'h1234;
  logic [15:0] sample_out;
  logic alarm_out;
  logic [15:0] exp_tab [9] = '{16'h8000, 16'h0800, 16'h1000, 16'h2100, 16'h0080,
                               16'h0020, 16'h0010, 16'h0008, 16'h0004};
  int errors = 0;
  int n_checks = 0;
  always #10 clk = ~clk;
  always @(negedge clk) if (conv_run) conv_tick <= ~conv_tick;
  always @(negedge clk) if (data_run) data_tick <= ~data_tick;
  alarm_status_and_temp_readout u_alarm_status_and_temp_readout (
    .clk(clk), .rst_n(rst_n), .sclk(sclk), .sden_n(sden_n), .sdio_in(sdio_in),
    .sdio_out(sdio_out), .sdio_oe(sdio_oe), .wr_ptr(wr_ptr), .ptr_two_away(two),
    .ptr_one_away(one), .ptr_collide(col), .conv_clk_tick(conv_tick),
    .input_data_clock_tick(data_tick), .pattern_mismatch(pat), .pll_unlock(pll),
    .parity_rise_err(rpe), .parity_fall_err(fpe), .parity_frame_err(frpe),
    .blank_conv_en(1'b1), .blank_data_en(1'b1), .blank_collide_en(1'b1),
    .temp_raw(temp_raw), .sample_in(sample_in), .sample_out(sample_out), .alarm_out(alarm_out));
  serial_host_model u_serial_host_model (
    .clk(clk), .sclk(sclk), .sden_n(sden_n), .sdio_in(sdio_in),
    .sdio_out(sdio_out), .sdio_oe(sdio_oe));
  ////////////////////////////////////////
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    logic [15:0] x;
    u_serial_host_model.xfer(1'b0, a, d, 5, x);
  endtask
  task automatic rd(input logic [6:0] a, input int half, input logic [15:0] exp, input string what);
    logic [15:0] x;
    u_serial_host_model.xfer(1'b1, a, 16'h0000, half, x);
    chk(what, exp, x);
  endtask
  task automatic set_src(input int k, input logic v);
    case (k)
      0: wr_ptr = v ? 8'h00 : 8'h01;
      1: two = v;
      2: one = v;
      3: col = v;
      4: pat = v;
      5: pll = v;
      6: rpe = v;
      7: fpe = v;
      default: frpe = v;
    endcase
  endtask
  task automatic wait_blank();
    int n;
    n = 0;
    while (sample_out !== `MID_SCALE && n < 300) begin
      @(negedge clk);
      n++;
    end
    chk("blanked sample", `MID_SCALE, sample_out);
    if (n >= 300) tally_and_finish();
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (100000) @(posedge clk);
    errors++;
    $display("CHECK FAILED run time expected end seen limit");
    tally_and_finish();
  end
  initial begin
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    rd(`ALARM_MASK_ADDR, 5, `MASK_RESET, "mask reset");
    wr(`ALARM_STATUS_ADDR, 16'h0000);
    rd(`ALARM_STATUS_ADDR, 5, 16'h0000, "status cleared");
    for (int k = 0; k < 9; k++) begin
      set_src(k, 1'b1);
      repeat (10) @(negedge clk);
      set_src(k, 1'b0);
      repeat (10) @(negedge clk);
      rd(`ALARM_STATUS_ADDR, 5, exp_tab[k], "latched flag");
      chk("sample out", (k == 3) ? `MID_SCALE : sample_in, sample_out);
      wr(`ALARM_STATUS_ADDR, 16'h0000);
      rd(`ALARM_STATUS_ADDR, 5, 16'h0000, "flag cleared");
      chk("sample resumed", sample_in, sample_out);
    end
    set_src(0, 1'b1);
    repeat (10) @(negedge clk);
    wr(`ALARM_STATUS_ADDR, 16'h0000);
    rd(`ALARM_STATUS_ADDR, 5, 16'h8000, "zero pointer held");
    set_src(0, 1'b0);
    wr(`ALARM_STATUS_ADDR, 16'h0000);
    for (int k = 0; k < 2; k++) begin
      if (k == 0) conv_run = 1'b0;
      else data_run = 1'b0;
      wait_blank();
      wr(`ALARM_STATUS_ADDR, 16'h0000);
      rd(`ALARM_STATUS_ADDR, 5, (k == 0) ? 16'h0500 : 16'h0300, "clock lost");
      conv_run = 1'b1;
      data_run = 1'b1;
      repeat (10) @(negedge clk);
      wr(`ALARM_STATUS_ADDR, 16'h0000);
      rd(`ALARM_STATUS_ADDR, 5, 16'h0000, "clock back");
      chk("sample resumed", sample_in, sample_out);
    end
    pat = 1'b1;
    repeat (10) @(negedge clk);
    chk("masked alarm", 16'h0000, {15'h0000, alarm_out});
    wr(`ALARM_MASK_ADDR, 16'hFF7F);
    repeat (5) @(negedge clk);
    chk("unmasked alarm", 16'h0001, {15'h0000, alarm_out});
    pat = 1'b0;
    wr(`ALARM_STATUS_ADDR, 16'h0000);
    repeat (5) @(negedge clk);
    chk("alarm cleared", 16'h0000, {15'h0000, alarm_out});
    temp_raw = 8'hE7;
    repeat (10) @(negedge clk);
    rd(`TEMP_READ_ADDR, 25, 16'hE700, "temperature");
    wr(`TEMP_READ_ADDR, 16'h1234);
    rd(`TEMP_READ_ADDR, 25, 16'hE700, "temperature read only");
    rd(7'h10, 5, 16'h0000, "unmapped read");
    tally_and_finish();
  end
endmodule // alarm_status_and_temp_readout_tb_top
`default_nettype wire
